// file: rtl/scsc_clock_slot_id.sv
// secondary clock gating, clock-run stop and slot identification registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "scsc_defines.svh"

module scsc_clock_slot_id #(
  parameter int NUM_CLK = 7
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // register port
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [31:0]        regRdata,
  // configuration and bridge status
  input  wire logic               forwardStrap,
  input  wire logic               slotIdEnable,
  input  wire logic               secBusIdle,
  input  wire logic               primaryReqPending,
  // secondary clock source and gated outputs
  input  wire logic               secClkIn,
  output logic      [NUM_CLK-1:0] secClkOut
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] clkSync_r;
  logic [2:0] fwdSync_r;
  logic       secLvl_r;
  logic       fwd_r;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      clkSync_r <= 3'h0;
      fwdSync_r <= 3'h0;
    end else begin
      clkSync_r <= {clkSync_r[1:0], secClkIn};
      fwdSync_r <= {fwdSync_r[1:0], forwardStrap};
    end
  end

  // filtered levels; strap is caught after reset release, never by the reset itself
  always_ff @(posedge clk) begin
    if (rst) begin
      secLvl_r <= 1'b0;
      fwd_r    <= 1'b0;
    end else begin
      if (clkSync_r[2] == clkSync_r[1]) secLvl_r <= clkSync_r[2];
      if (fwdSync_r[2] == fwdSync_r[1]) fwd_r <= fwdSync_r[2];
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  scsc_pkg::scsc_ctl_t  ctl_r;
  scsc_pkg::scsc_slot_t slot_r;
  logic [1:0]           pwrState_r;
  logic                 stopped_r;
  logic                 pmWr;
  logic                 slotWr;
  logic                 ctlWr;

  assign pmWr   = regWr && (regAddr == `SCSC_PM_CSR_OFS);
  assign slotWr = regWr && (regAddr == `SCSC_SLOT_ID_OFS) && slotIdEnable;
  assign ctlWr  = regWr && (regAddr == `SCSC_CLK_CTL_OFS);

  // clock control word
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r <= scsc_pkg::scsc_ctl_t'({2'h0, 3'h0, 8'h00});
    end else if (ctlWr) begin
      ctl_r <= scsc_pkg::scsc_ctl_t'({regWdata[`SCSC_RUN_MODE_BIT],
                                      regWdata[`SCSC_RUN_EN_BIT],
                                      regWdata[10:0]});
    end
  end

  // power state; unimplemented D1/D2 writes leave the state alone
  always_ff @(posedge clk) begin
    if (rst) begin
      pwrState_r <= `SCSC_PWR_D0;
    end else if (pmWr && (regWdata[1:0] == `SCSC_PWR_D0 || regWdata[1:0] == `SCSC_PWR_D3)) begin
      pwrState_r <= regWdata[1:0];
    end
  end

  // slot identification storage, writable only while the capability is present
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_r <= '0;
    end else if (slotWr) begin
      slot_r <= {regWdata[31:24], regWdata[21], regWdata[20:16]};
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [31:0] rdMux;

  // upper half of the pm word is the bridge extension, all zero
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (regAddr)
      `SCSC_PM_CSR_OFS: begin
        rdMux = {8'h00, 1'b0, 1'b0, 6'h00, 14'h0000, pwrState_r};
      end
      `SCSC_SLOT_ID_OFS: begin
        if (slotIdEnable) begin
          rdMux = {slot_r.chassis, 2'h0, slot_r.firstInChassis, slot_r.slotNum,
                   `SCSC_SLOT_ID_NEXT, `SCSC_SLOT_ID_CAP};
        end
      end
      `SCSC_CLK_CTL_OFS: rdMux = {16'h0000, ctl_r.runMode, ctl_r.runEnable, stopped_r,
                                  2'h0, ctl_r.devOff, ctl_r.slotCode};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) regRdata <= 32'h0000_0000;
    else     regRdata <= regRd ? rdMux : 32'h0000_0000;
  end

  // ****************************************************************
  // clock stop and gating
  // ****************************************************************
  logic               stopReq;
  logic [NUM_CLK-1:0] userOff;
  logic [NUM_CLK-1:0] gateOn_r;

  // idle and pending come from bridge logic on this clock, so no synchroniser
  assign stopReq = ctl_r.runEnable &&
                   (ctl_r.runMode ? (secBusIdle && !primaryReqPending)
                                  : (pwrState_r == `SCSC_PWR_D3));

  // per-output disable requests; codes 00..10 all mean run
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CLK; gi++) begin : g_off
      if (gi < 4) begin : g_slot
        assign userOff[gi] = (ctl_r.slotCode[gi] == `SCSC_SLOT_OFF);
      end else begin : g_dev
        assign userOff[gi] = ctl_r.devOff[gi-4];
      end
    end
  endgenerate

  // gates move only while the sampled clock is low, so no runt pulse reaches a slot
  always_ff @(posedge clk) begin
    if (rst) begin
      gateOn_r  <= '1;
      stopped_r <= 1'b0;
    end else if (!secLvl_r) begin
      stopped_r <= stopReq;
      gateOn_r  <= {NUM_CLK{!stopReq}} & ~(userOff & {NUM_CLK{fwd_r}});
    end
  end

  // outputs from flops; a closed gate holds the pin low
  always_ff @(posedge clk) begin
    if (rst) secClkOut <= '0;
    else     secClkOut <= {NUM_CLK{secLvl_r}} & gateOn_r;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // per-output gate checks
  // ****************************************************************
  // slot 0 pin low two edges after a stop code seen in a low phase
  slot0_off_a: assert property (
    !secLvl_r && fwd_r && ctl_r.slotCode[0] == `SCSC_SLOT_OFF |=> ##1 !secClkOut[0]
  ) else $error("slot 0 clock not held low");

  // every run code keeps slot 0 fed
  slot0_run_a: assert property (
    !secLvl_r && !stopReq && ctl_r.slotCode[0] != `SCSC_SLOT_OFF |=> gateOn_r[0]
  ) else $error("slot 0 gate closed");

  // slot 1 gate closes on its stop code
  slot1_off_a: assert property (
    !secLvl_r && fwd_r && ctl_r.slotCode[1] == `SCSC_SLOT_OFF |=> !gateOn_r[1]
  ) else $error("slot 1 gate open");

  // codes 01 and 10 run the slot too, there is no half-way state
  slot1_run_a: assert property (
    !secLvl_r && !stopReq && ctl_r.slotCode[1] != `SCSC_SLOT_OFF |=> gateOn_r[1]
  ) else $error("slot 1 gate closed");

  // slot 2 gate closes on its stop code
  slot2_off_a: assert property (
    !secLvl_r && fwd_r && ctl_r.slotCode[2] == `SCSC_SLOT_OFF |=> !gateOn_r[2]
  ) else $error("slot 2 gate open");

  // slot 3 stays open on codes 00 to 10
  slot3_run_a: assert property (
    !secLvl_r && !stopReq && ctl_r.slotCode[3] != `SCSC_SLOT_OFF |=> gateOn_r[3]
  ) else $error("slot 3 gate closed");

  // device 1 gate closes on its stop bit
  dev1_off_a: assert property (
    !secLvl_r && fwd_r && ctl_r.devOff[0] |=> !gateOn_r[4]
  ) else $error("device 1 gate open");

  // device 1 gate open while its bit is clear
  dev1_run_a: assert property (
    !secLvl_r && !stopReq && !ctl_r.devOff[0] |=> gateOn_r[4]
  ) else $error("device 1 gate closed");

  // device 2 gate closes on its stop bit
  dev2_off_a: assert property (
    !secLvl_r && fwd_r && ctl_r.devOff[1] |=> !gateOn_r[5]
  ) else $error("device 2 gate open");

  // device 2 gate open while its bit is clear
  dev2_run_a: assert property (
    !secLvl_r && !stopReq && !ctl_r.devOff[1] |=> gateOn_r[5]
  ) else $error("device 2 gate closed");

  // feedback gate closes on its stop bit; the bridge then loses its own clock
  bridge_off_a: assert property (
    !secLvl_r && fwd_r && ctl_r.devOff[2] |=> !gateOn_r[6]
  ) else $error("feedback gate open");

  // feedback gate open while its bit is clear
  bridge_run_a: assert property (
    !secLvl_r && !stopReq && !ctl_r.devOff[2] |=> gateOn_r[6]
  ) else $error("feedback gate closed");

  // reverse mode ignores every user disable
  reverse_run_a: assert property (
    !secLvl_r && !fwd_r && !stopReq |=> &gateOn_r
  ) else $error("reverse mode gated a clock");

  // a closed gate means a low pin on the next edge, whatever the source level
  closed_low_a: assert property (
    1'b1 |=> (secClkOut & ~$past(gateOn_r)) == '0
  ) else $error("closed gate let a clock through");

  // ****************************************************************
  // clock stop checks
  // ****************************************************************
  // once stopped for two edges every pin is low
  stop_low_a: assert property (
    stopped_r && $past(stopped_r) |=> secClkOut == '0
  ) else $error("clock toggles while stopped");

  // status and gates move in the same edge, so software never reads a stale stop
  stop_gate_a: assert property (
    stopped_r |-> gateOn_r == '0
  ) else $error("stopped with a gate open");

  // protocol off never stops the clock, in either mode
  run_off_a: assert property (
    !secLvl_r && !ctl_r.runEnable |=> !stopped_r
  ) else $error("stopped with protocol off");

  // mode 0 outside D3hot keeps running
  mode0_d3_a: assert property (
    !secLvl_r && ctl_r.runEnable && !ctl_r.runMode && pwrState_r != `SCSC_PWR_D3 |=> !stopped_r
  ) else $error("stopped outside D3hot");

  // mode 0 in D3hot stops
  mode0_stop_a: assert property (
    !secLvl_r && ctl_r.runEnable && !ctl_r.runMode && pwrState_r == `SCSC_PWR_D3 |=> stopped_r
  ) else $error("D3hot did not stop");

  // mode 1 with an idle bus and nothing pending stops
  mode1_idle_a: assert property (
    !secLvl_r && ctl_r.runEnable && ctl_r.runMode && secBusIdle && !primaryReqPending
      |=> stopped_r
  ) else $error("idle bus not stopped");

  // mode 1 with traffic on either side keeps running
  mode1_busy_a: assert property (
    !secLvl_r && ctl_r.runEnable && ctl_r.runMode && (!secBusIdle || primaryReqPending)
      |=> !stopped_r
  ) else $error("busy bus stopped");

  // ****************************************************************
  // runt pulse guard
  // ****************************************************************
  // gates move only after a low sample of the source
  no_runt_a: assert property (
    $changed(gateOn_r) |-> !$past(secLvl_r)
  ) else $error("gate moved in high phase");

  // a high sample freezes gates and status for that edge
  gate_hold_a: assert property (
    secLvl_r |=> $stable(gateOn_r) && $stable(stopped_r)
  ) else $error("gate changed during high phase");

  // a pin is high only after a high sample, so it never leads the source
  high_level_a: assert property (
    |secClkOut |-> $past(secLvl_r)
  ) else $error("clock high without source high");

  // ****************************************************************
  // register checks
  // ****************************************************************
  // header of the slot id capability while it is present
  cap_id_a: assert property (
    regRd && regAddr == `SCSC_SLOT_ID_OFS && slotIdEnable
      |=> regRdata[15:0] == {`SCSC_SLOT_ID_NEXT, `SCSC_SLOT_ID_CAP}
  ) else $error("slot id header wrong");

  // an absent capability reads as zero
  slot_hidden_a: assert property (
    regRd && regAddr == `SCSC_SLOT_ID_OFS && !slotIdEnable |=> regRdata == 32'h0000_0000
  ) else $error("absent capability visible");

  // and keeps its storage untouched
  slot_lock_a: assert property (
    regWr && regAddr == `SCSC_SLOT_ID_OFS && !slotIdEnable |=> $stable(slot_r)
  ) else $error("absent capability written");

  // reserved bits between slot number and chassis read zero
  slot_rsvd_a: assert property (
    regRd && regAddr == `SCSC_SLOT_ID_OFS |=> regRdata[23:22] == 2'h0
  ) else $error("slot reserved bits set");

  // storage takes the written fields as they are
  slot_store_a: assert property (
    slotWr |=> slot_r.chassis == $past(regWdata[31:24])
           && slot_r.firstInChassis == $past(regWdata[21])
           && slot_r.slotNum == $past(regWdata[20:16])
  ) else $error("slot fields not stored");

  // the extension half and the rest of the pm word read zero
  pm_upper_a: assert property (
    regRd && regAddr == `SCSC_PM_CSR_OFS |=> regRdata[31:2] == 30'h0000_0000
  ) else $error("pm word bits set");

  // unimplemented power states leave the state alone
  pwr_ignore_a: assert property (
    pmWr && (regWdata[1:0] == 2'h1 || regWdata[1:0] == 2'h2) |=> $stable(pwrState_r)
  ) else $error("D1/D2 write accepted");

  // a D3 write is taken
  pwr_take_a: assert property (
    pmWr && regWdata[1:0] == `SCSC_PWR_D3 |=> pwrState_r == `SCSC_PWR_D3
  ) else $error("D3 write dropped");

  // only D0 and D3 can ever be held
  pwr_legal_a: assert property (
    pwrState_r == `SCSC_PWR_D0 || pwrState_r == `SCSC_PWR_D3
  ) else $error("illegal power state held");

  // reserved control bits read zero
  ctl_rsvd_a: assert property (
    regRd && regAddr == `SCSC_CLK_CTL_OFS
      |=> regRdata[31:16] == 16'h0000 && regRdata[12:11] == 2'h0
  ) else $error("control reserved bits set");

  // control word takes the written codes and bits
  ctl_store_a: assert property (
    ctlWr |=> ctl_r.slotCode == $past(regWdata[7:0]) && ctl_r.devOff == $past(regWdata[10:8])
          && ctl_r.runEnable == $past(regWdata[`SCSC_RUN_EN_BIT])
          && ctl_r.runMode == $past(regWdata[`SCSC_RUN_MODE_BIT])
  ) else $error("control word not stored");

  // status bit reads back what the gating logic holds
  stat_read_a: assert property (
    regRd && regAddr == `SCSC_CLK_CTL_OFS |=> regRdata[`SCSC_STOP_BIT] == $past(stopped_r)
  ) else $error("stop status read wrong");

  // read data stand for one cycle only
  rdata_idle_a: assert property (
    !regRd |=> regRdata == 32'h0000_0000
  ) else $error("read data without a read");

endmodule
`default_nettype wire

// file: rtl/scsc_defines.svh
// constants for the secondary clock, slot identification and bridge extension registers
`ifndef SCSC_DEFINES_SVH
`define SCSC_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SCSC_PM_CSR_OFS     8'h94
`define SCSC_SLOT_ID_OFS    8'ha0
`define SCSC_CLK_CTL_OFS    8'ha4

// ****************************************************************
// fields and reset values
// ****************************************************************
`define SCSC_SLOT_ID_CAP    8'h04
`define SCSC_SLOT_ID_NEXT   8'hb0
`define SCSC_PWR_D0         2'h0
`define SCSC_PWR_D3         2'h3
`define SCSC_SLOT_OFF       2'h3
`define SCSC_STOP_BIT       13
`define SCSC_RUN_EN_BIT     14
`define SCSC_RUN_MODE_BIT   15
`define SCSC_CLK_RESET      11'h000

`endif

// file: rtl/scsc_pkg.sv
// types shared by the secondary clock and slot identification logic
package scsc_pkg;

  // software clock control word, low sixteen bits of the control register
  typedef struct packed {
    logic            runMode;
    logic            runEnable;
    logic [2:0]      devOff;    // bit 2 bridge feedback, 1 device 2, 0 device 1
    logic [3:0][1:0] slotCode;  // one two-bit code per slot
  } scsc_ctl_t;

  // slot identification storage
  typedef struct packed {
    logic [7:0] chassis;
    logic       firstInChassis;
    logic [4:0] slotNum;
  } scsc_slot_t;

endpackage

// file: tb/scsc_sec_bus_model.sv
// secondary bus model: free running clock source and runt pulse monitor
`timescale 1ns/100ps
`default_nettype none

module scsc_sec_bus_model (
  // clock source towards the bridge
  output logic            secClkIn,
  // gated clocks received by the slots and devices
  input  wire logic [6:0] secClkOut,
  // shortest high pulse seen on any output, in ns
  output realtime         minHigh
);
  realtime riseAt [7];
  logic    [6:0] prev = 7'h00;

  // a pci clock runs free, so the source never pauses
  initial begin
    secClkIn = 1'b0;
    minHigh = 1000.0;
    forever #100 secClkIn = ~secClkIn;
  end

  // a receiver would misclock on a shortened high phase
  always @(secClkOut) begin
    for (int i = 0; i < 7; i++) begin
      if (secClkOut[i] && !prev[i]) riseAt[i] = $realtime;
      if (!secClkOut[i] && prev[i] && ($realtime - riseAt[i] < minHigh)) begin
        minHigh = $realtime - riseAt[i];
      end
    end
    prev = secClkOut;
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// register, clock gating and clock stop tests of the secondary clock block
`timescale 1ns/100ps
`default_nettype none
`include "scsc_defines.svh"

module testbench;
  logic        clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, r;
  logic        forwardStrap = 1'b1, slotIdEnable = 1'b0, secBusIdle = 1'b0;
  logic        primaryReqPending = 1'b0, secClkIn;
  logic [6:0]  secClkOut, hi;
  realtime     minHigh;
  int          err_total = 0, cmp_count = 0;
  logic [15:0] gv [9] = '{16'h0024, 16'h0003, 16'h000c, 16'h0030, 16'h00c0,
                          16'h0100, 16'h0200, 16'h0400, 16'h07ff};
  logic [6:0]  gm [9] = '{7'h7f, 7'h7e, 7'h7d, 7'h7b, 7'h77, 7'h6f, 7'h5f, 7'h3f, 7'h7f};

  scsc_clock_slot_id scsc_clock_slot_id_i (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .forwardStrap(forwardStrap), .slotIdEnable(slotIdEnable), .secBusIdle(secBusIdle),
    .primaryReqPending(primaryReqPending), .secClkIn(secClkIn), .secClkOut(secClkOut));
  scsc_sec_bus_model scsc_sec_bus_model_i (.secClkIn(secClkIn), .secClkOut(secClkOut),
    .minHigh(minHigh));

  // ****************************************************************
  // bus tasks and comparison
  // ****************************************************************
  initial forever #12.5 clk = ~clk;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a; regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk) d = regRdata;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // five slow clock periods, enough to see every running output high
  task automatic win();
    repeat (12) @(posedge clk);
    hi = 7'h00;
    repeat (40) @(negedge clk) hi |= secClkOut;
  endtask

  task automatic step(input logic [15:0] c, input logic [1:0] pm, input logic pend,
                      input logic [6:0] m, input logic st);
    wr(`SCSC_CLK_CTL_OFS, {16'h0, c});
    wr(`SCSC_PM_CSR_OFS, {30'h0, pm});
    @(posedge clk) primaryReqPending <= pend;
    win();
    chk("clkMask", {25'h0, m}, {25'h0, hi});
    rd(`SCSC_CLK_CTL_OFS, r);
    chk("stopStatus", {18'h0, st, 13'h0}, r & 32'h2000);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #200us;
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`SCSC_CLK_CTL_OFS, r); chk("ctlReset", 32'h0, r);
    rd(`SCSC_SLOT_ID_OFS, r); chk("slotIdOff", 32'h0, r);
    @(posedge clk) slotIdEnable <= 1'b1;
    rd(`SCSC_SLOT_ID_OFS, r); chk("slotIdOn", 32'h0000b004, r);
    wr(`SCSC_SLOT_ID_OFS, 32'hffffffff);
    rd(`SCSC_SLOT_ID_OFS, r); chk("slotIdRw", 32'hff3fb004, r);
    rd(8'h98, r); chk("unmapped", 32'h0, r);
    wr(`SCSC_PM_CSR_OFS, 32'hffffffff);
    rd(`SCSC_PM_CSR_OFS, r); chk("pmD3", 32'h3, r);
    wr(`SCSC_PM_CSR_OFS, 32'h1);
    rd(`SCSC_PM_CSR_OFS, r); chk("pmIgnore", 32'h3, r);
    wr(`SCSC_PM_CSR_OFS, 32'h0);
    wr(`SCSC_CLK_CTL_OFS, 32'hffffffff);
    rd(`SCSC_CLK_CTL_OFS, r); chk("ctlRw", 32'h0000c7ff, r);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk) forwardStrap <= (i != 8);
      wr(`SCSC_CLK_CTL_OFS, {16'h0, gv[i]});
      win();
      chk("gateMask", 32'(gm[i]), 32'(hi));
    end
    @(posedge clk) forwardStrap <= 1'b1;
    @(posedge clk) secBusIdle <= 1'b1;
    step(16'hc000, 2'h0, 1'b0, 7'h00, 1'b1);
    step(16'hc000, 2'h0, 1'b1, 7'h7f, 1'b0);
    step(16'h4000, 2'h0, 1'b0, 7'h7f, 1'b0);
    step(16'h4000, 2'h3, 1'b0, 7'h00, 1'b1);
    step(16'h0000, 2'h3, 1'b0, 7'h7f, 1'b0);
    chk("noRunt", 32'h1, {31'h0, minHigh >= 75.0});
    tally_and_finish();
  end
endmodule
`default_nettype wire
